// file: hw/op_event_latch.sv
`timescale 1ns/10ps
module op_event_latch
  import op_status_pkg::*;
(
  // Clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  // Latch carrier
  op_filter_if.latch l
);

  reg_t events_q;
  reg_t events_d;

  // A new hit wins over a clear in the same cycle.
  always_comb begin
    events_d = (l.clr ? ZERO_WORD : events_q) | l.hit;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      events_q <= ZERO_WORD;
    end else begin
      events_q <= events_d;
    end
  end

  assign l.events = events_q;

endmodule

// file: hw/op_filter_if.sv
`timescale 1ns/10ps
interface op_filter_if;
  import op_status_pkg::*;

  reg_t cond;
  reg_t rise;
  reg_t fall;
  reg_t hit;
  logic clr;
  reg_t events;

  modport ctrl (output cond, output rise, output fall, output clr,
                input hit, input events);
  modport filt (input cond, input rise, input fall, output hit);
  modport latch (input hit, input clr, output events);
endinterface

// file: hw/op_status_group.sv
`timescale 1ns/10ps
module op_status_group
  import op_status_pkg::*;
(
  // Clock and reset
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_rst_n,
  // Live operating state from device logic on this clock
  input  wire logic                 i_calibrating,
  input  wire logic                 i_awaiting_trigger_flag,
  input  wire logic                 i_main_const_voltage_flag,
  input  wire logic                 i_aux_const_voltage_flag,
  input  wire logic                 i_positive_const_current_flag,
  input  wire logic                 i_negative_const_current_flag,
  input  wire logic                 i_aux_const_current_flag,
  // Host command port
  input  wire logic                 i_cmd_valid,
  input  wire logic [1:0]           i_cmd_op,
  input  wire logic [2:0]           i_cmd_sel,
  input  wire logic [REG_W-1:0]     i_cmd_wdata,
  // Host response
  output logic                      o_rsp_valid,
  output logic [REG_W-1:0]          o_rsp_data,
  // Status byte contribution
  output logic                      o_operation_summary_bit
);

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  logic cmd_read;
  logic cmd_write;
  logic cmd_preset;

  // The spare op code decodes to nothing, so a stray code leaves every register alone.
  always_comb begin
    cmd_read   = 1'b0;
    cmd_write  = 1'b0;
    cmd_preset = 1'b0;
    if (i_cmd_valid) begin
      unique case (cmd_op_e'(i_cmd_op))
        OP_READ:   cmd_read   = 1'b1;
        OP_WRITE:  cmd_write  = 1'b1;
        OP_PRESET: cmd_preset = 1'b1;
        default:   cmd_read   = 1'b0;
      endcase
    end
  end

  function automatic logic sel_is(input logic [2:0] sel, input reg_sel_e which);
    sel_is = (reg_sel_e'(sel) == which);
  endfunction

  // Bit 15 is outside the host's value range and is never stored.
  function automatic reg_t host_word(input reg_t wdata);
    host_word = wdata & WRITABLE_MASK;
  endfunction

  // ----------------------------------------------------------------------
  // Register strobes
  // ----------------------------------------------------------------------
  logic wr_mask;
  logic wr_fall;
  logic wr_rise;
  logic rd_events;

  // Writes aimed at the read-only or unmapped selects match no strobe.
  assign wr_mask   = cmd_write && sel_is(i_cmd_sel, SEL_MASK);
  assign wr_fall   = cmd_write && sel_is(i_cmd_sel, SEL_FALL);
  assign wr_rise   = cmd_write && sel_is(i_cmd_sel, SEL_RISE);
  assign rd_events = cmd_read && sel_is(i_cmd_sel, SEL_EVENTS);

  // ----------------------------------------------------------------------
  // Live state capture
  // ----------------------------------------------------------------------
  reg_t live_q;
  reg_t live_d;

  always_comb begin
    live_d                = ZERO_WORD;
    live_d[CAL_BIT]       = i_calibrating;
    live_d[WAIT_TRIG_BIT] = i_awaiting_trigger_flag;
    live_d[MAIN_VOLT_BIT] = i_main_const_voltage_flag;
    live_d[AUX_VOLT_BIT]  = i_aux_const_voltage_flag;
    live_d[POS_CURR_BIT]  = i_positive_const_current_flag;
    live_d[NEG_CURR_BIT]  = i_negative_const_current_flag;
    live_d[AUX_CURR_BIT]  = i_aux_const_current_flag;
  end

  // One register stage so the compared and reported value is glitch free.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      live_q <= ZERO_WORD;
    end else begin
      live_q <= live_d;
    end
  end

  // ----------------------------------------------------------------------
  // Host writable registers
  // ----------------------------------------------------------------------
  reg_t mask_q;
  reg_t fall_q;
  reg_t rise_q;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mask_q <= MASK_PRESET;
    end else if (cmd_preset) begin
      mask_q <= MASK_PRESET;
    end else if (wr_mask) begin
      mask_q <= host_word(i_cmd_wdata);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fall_q <= FALL_PRESET;
    end else if (cmd_preset) begin
      fall_q <= FALL_PRESET;
    end else if (wr_fall) begin
      fall_q <= host_word(i_cmd_wdata);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rise_q <= RISE_PRESET;
    end else if (cmd_preset) begin
      rise_q <= RISE_PRESET;
    end else if (wr_rise) begin
      rise_q <= host_word(i_cmd_wdata);
    end
  end

  // ----------------------------------------------------------------------
  // Transition filter and event latch
  // ----------------------------------------------------------------------
  op_filter_if fx ();

  assign fx.cond = live_q;
  assign fx.rise = rise_q;
  assign fx.fall = fall_q;
  // Clearing on the read itself returns the pre-clear contents below.
  assign fx.clr  = rd_events;

  op_transition_filter u_filter (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .f         (fx.filt)
  );

  op_event_latch u_latch (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .l         (fx.latch)
  );

  // ----------------------------------------------------------------------
  // Read response
  // ----------------------------------------------------------------------
  reg_t rsp_d;

  always_comb begin
    unique case (reg_sel_e'(i_cmd_sel))
      SEL_LIVE_STATE: rsp_d = live_q;
      SEL_EVENTS:     rsp_d = fx.events;
      SEL_MASK:       rsp_d = mask_q;
      SEL_FALL:       rsp_d = fall_q;
      SEL_RISE:       rsp_d = rise_q;
      default:        rsp_d = ZERO_WORD;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rsp_valid <= 1'b0;
      o_rsp_data  <= ZERO_WORD;
    end else begin
      o_rsp_valid <= cmd_read;
      if (cmd_read) begin
        o_rsp_data <= rsp_d;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Summary bit
  // ----------------------------------------------------------------------
  reg_t enabled_events;

  assign enabled_events = fx.events & mask_q;

  // Registered for a clean output, at the cost of one cycle of lag.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_operation_summary_bit <= 1'b0;
    end else begin
      o_operation_summary_bit <= |enabled_events;
    end
  end

endmodule

// file: hw/op_status_pkg.sv
package op_status_pkg;

  // ----------------------------------------------------------------------
  // Widths and bit map
  // ----------------------------------------------------------------------
  localparam int unsigned REG_W = 16;

  typedef logic [REG_W-1:0] reg_t;

  localparam int unsigned CAL_BIT        = 0;
  localparam int unsigned WAIT_TRIG_BIT  = 5;
  localparam int unsigned MAIN_VOLT_BIT  = 8;
  localparam int unsigned AUX_VOLT_BIT   = 9;
  localparam int unsigned POS_CURR_BIT   = 10;
  localparam int unsigned NEG_CURR_BIT   = 11;
  localparam int unsigned AUX_CURR_BIT   = 12;
  localparam int unsigned SUMMARY_BIT    = 7;

  // Positions that carry a live condition.
  localparam reg_t DEFINED_MASK   = 16'h1F21;
  // Host values are limited to 0..32767, so bit 15 never stores.
  localparam reg_t WRITABLE_MASK  = 16'h7FFF;

  // ----------------------------------------------------------------------
  // Reset and preset values
  // ----------------------------------------------------------------------
  localparam reg_t RISE_PRESET    = 16'h7FFF;
  localparam reg_t FALL_PRESET    = 16'h0000;
  localparam reg_t MASK_PRESET    = 16'h0000;
  localparam reg_t ZERO_WORD      = 16'h0000;

  // ----------------------------------------------------------------------
  // Command port encodings
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_READ   = 2'h0,
    OP_WRITE  = 2'h1,
    OP_PRESET = 2'h3
  } cmd_op_e;

  typedef enum logic [2:0] {
    SEL_LIVE_STATE = 3'h0,
    SEL_EVENTS     = 3'h1,
    SEL_MASK       = 3'h2,
    SEL_FALL       = 3'h3,
    SEL_RISE       = 3'h4
  } reg_sel_e;

endpackage

// file: hw/op_transition_filter.sv
`timescale 1ns/10ps
module op_transition_filter
  import op_status_pkg::*;
(
  // Clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  // Filter carrier
  op_filter_if.filt f
);

  reg_t prev_q;

  // Previous cycle's condition, the reference for edge detection.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_q <= ZERO_WORD;
    end else begin
      prev_q <= f.cond;
    end
  end

  // Both filter bits set pass either edge; both clear pass nothing.
  assign f.hit = (( f.cond & ~prev_q & f.rise)
               |  (~f.cond &  prev_q & f.fall))
               & DEFINED_MASK;

endmodule

// file: verification/op_status_group_chk.sv
`timescale 1ns/10ps
module op_status_group_chk
  import op_status_pkg::*;
(
  // Clock and reset
  input wire logic             i_sys_clk,
  input wire logic             i_rst_n,
  // Live state
  input wire logic             i_calibrating,
  input wire logic             i_awaiting_trigger_flag,
  input wire logic             i_main_const_voltage_flag,
  input wire logic             i_aux_const_voltage_flag,
  input wire logic             i_positive_const_current_flag,
  input wire logic             i_negative_const_current_flag,
  input wire logic             i_aux_const_current_flag,
  // Host side
  input wire logic             i_cmd_valid,
  input wire logic [1:0]       i_cmd_op,
  input wire logic [2:0]       i_cmd_sel,
  input wire logic [REG_W-1:0] i_cmd_wdata,
  input wire logic             o_rsp_valid,
  input wire logic [REG_W-1:0] o_rsp_data,
  input wire logic             o_operation_summary_bit
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  wire logic rd = i_cmd_valid && i_cmd_op == 2'h0;
  wire reg_t live = {3'h0, i_aux_const_current_flag, i_negative_const_current_flag,
    i_positive_const_current_flag, i_aux_const_voltage_flag, i_main_const_voltage_flag,
    2'h0, i_awaiting_trigger_flag, 4'h0, i_calibrating};
  a_read_answers: assert property (rd |=> o_rsp_valid)
    else $error("read not answered");
  a_quiet_else: assert property (!rd |=> !o_rsp_valid)
    else $error("answer without read");
  a_data_holds: assert property (!o_rsp_valid |-> $stable(o_rsp_data))
    else $error("read data moved");
  a_unused_zero: assert property (rd && i_cmd_sel <= 3'h1 |=>
    (o_rsp_data & ~DEFINED_MASK) == ZERO_WORD) else $error("unused bit set");
  a_unmapped_zero: assert property (rd && i_cmd_sel >= 3'h5 |=>
    o_rsp_data == ZERO_WORD) else $error("unmapped read not zero");
  // The reset guard lets the live copy leave its reset value before comparing.
  a_live_echo: assert property (rd && i_cmd_sel == 3'h0 && $stable(live) &&
    $past(i_rst_n) |=> o_rsp_data == $past(live)) else $error("live read wrong");
  a_preset_quiet: assert property (i_cmd_valid && i_cmd_op == 2'h3 ##1
    !i_cmd_valid |=> !o_operation_summary_bit) else $error("summary after preset");
  // The summary is registered, so the cycle after the read still shows the old events.
  a_clear_summary: assert property ($stable(live)[*3] ##0 (rd &&
    i_cmd_sel == 3'h1) |=> ##1 !o_operation_summary_bit[*2]) else $error("summary stuck");
  c_event_read: cover property (rd && i_cmd_sel == 3'h1);
  c_summary_up: cover property ($rose(o_operation_summary_bit));
  c_preset: cover property (i_cmd_valid && i_cmd_op == 2'h3);
endmodule

bind op_status_group op_status_group_chk chk (
  .i_sys_clk, .i_rst_n, .i_calibrating, .i_awaiting_trigger_flag,
  .i_main_const_voltage_flag, .i_aux_const_voltage_flag, .i_positive_const_current_flag,
  .i_negative_const_current_flag, .i_aux_const_current_flag, .i_cmd_valid, .i_cmd_op,
  .i_cmd_sel, .i_cmd_wdata, .o_rsp_valid, .o_rsp_data, .o_operation_summary_bit);

// file: verification/testbench.sv
`timescale 1ns/10ps
module testbench;
  import op_status_pkg::*;
  logic        i_sys_clk = 1'b0;
  logic        i_rst_n   = 1'b0;
  logic        vld       = 1'b0;
  logic [6:0]  flags     = 7'h00;
  logic [20:0] req       = 21'h00000;
  logic        rsp_v;
  reg_t        rsp_d;
  logic        summ;
  int          fails     = 0;
  int          compares  = 0;
  int          cyc       = 0;
  int          pos [7]   = '{0, 5, 8, 9, 10, 11, 12};
  logic [36:0] rows [12];

  always #5 i_sys_clk = ~i_sys_clk;

  op_status_group dut (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_calibrating(flags[0]), .i_awaiting_trigger_flag(flags[1]),
    .i_main_const_voltage_flag(flags[2]), .i_aux_const_voltage_flag(flags[3]),
    .i_positive_const_current_flag(flags[4]), .i_negative_const_current_flag(flags[5]),
    .i_aux_const_current_flag(flags[6]), .i_cmd_valid(vld), .i_cmd_op(req[20:19]),
    .i_cmd_sel(req[18:16]), .i_cmd_wdata(req[15:0]), .o_rsp_valid(rsp_v),
    .o_rsp_data(rsp_d), .o_operation_summary_bit(summ)
  );

  task automatic wrap_up();
    if (fails == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic chk(input reg_t got, input reg_t exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask

  task automatic cmd(input logic [20:0] r);
    idle(1);
    vld = 1'b1;
    req = r;
    idle(1);
    vld = 1'b0;
  endtask

  task automatic rd(input logic [2:0] s, input reg_t e);
    cmd({2'h0, s, 16'h0000});
    chk({15'h0000, rsp_v}, 16'h0001);
    chk(rsp_d, e);
  endtask

  initial begin
    rows = '{{2'h0, 3'h4, 16'h0000, 16'h7FFF}, {2'h1, 3'h3, 16'h5A5A, 16'h0000},
      {2'h0, 3'h3, 16'h0000, 16'h5A5A}, {2'h1, 3'h2, 16'h7FFF, 16'h0000},
      {2'h0, 3'h2, 16'h0000, 16'h7FFF}, {2'h2, 3'h2, 16'h0001, 16'h0000},
      {2'h0, 3'h2, 16'h0000, 16'h7FFF}, {2'h3, 3'h0, 16'h0000, 16'h0000},
      {2'h0, 3'h4, 16'h0000, 16'h7FFF}, {2'h0, 3'h3, 16'h0000, 16'h0000},
      {2'h0, 3'h2, 16'h0000, 16'h0000}, {2'h0, 3'h5, 16'h0000, 16'h0000}};
    // Inputs stay low through reset so no event is pending at release.
    idle(12);
    i_rst_n = 1'b1;
    foreach (rows[i]) begin
      if (rows[i][36:35] == 2'h0) begin
        rd(rows[i][34:32], rows[i][15:0]);
      end else begin
        cmd(rows[i][36:16]);
      end
    end
    foreach (pos[k]) begin
      flags[k] = 1'b1;
      idle(3);
      rd(3'h1, 16'h0001 << pos[k]);
      rd(3'h1, 16'h0000);
    end
    rd(3'h0, DEFINED_MASK);
    flags = 7'h00;
    idle(3);
    rd(3'h1, 16'h0000);
    cmd({2'h1, 3'h4, 16'h0000});
    flags = 7'h7F;
    idle(3);
    rd(3'h1, 16'h0000);
    cmd({2'h1, 3'h3, 16'h1F21});
    flags = 7'h00;
    idle(3);
    rd(3'h1, 16'h1F21);
    cmd({2'h1, 3'h4, 16'h1F21});
    flags = 7'h7F;
    idle(3);
    rd(3'h1, 16'h1F21);
    flags = 7'h00;
    idle(3);
    rd(3'h1, 16'h1F21);
    cmd({2'h1, 3'h2, 16'h0020});
    flags = 7'h02;
    idle(4);
    chk({15'h0000, summ}, 16'h0001);
    rd(3'h1, 16'h0020);
    idle(2);
    chk({15'h0000, summ}, 16'h0000);
    flags = 7'h03;
    idle(4);
    chk({15'h0000, summ}, 16'h0000);
    rd(3'h1, 16'h0001);
    flags = 7'h07;
    rd(3'h1, 16'h0000);
    rd(3'h1, 16'h0100);
    cmd({2'h1, 3'h3, 16'h00FF});
    i_rst_n = 1'b0;
    idle(2);
    i_rst_n = 1'b1;
    rd(3'h3, 16'h0000);
    rd(3'h4, 16'h7FFF);
    wrap_up();
  end
endmodule
